// ### src/sfb_top.sv
// burst flash sequencer between a 32-bit processor bus and flash
// assumes processor, flash and this block share CLK_SYS_IN
// Operation
// - strobe low with write high starts write
// - counter loads address bits 3:2 first edge
// - write strobe falls between edges one, two
// - write strobe low for two clock periods
// - power-up configuration: single writes only
// - power-up: hold until last transfer, idle
// - optimized: fourth edge increments, strobe again
// - burst continues until last transfer asserted
// - chip select lingers one extra clock
// - counter stable before write strobe falls
// - generate output, write, address-valid strobes
// - ready/receive inserts wait states
// - every cycle loads counter, drives burst bits
// - optimized reads run 5-1-1-1
// - chip select held until last, strobe high
`timescale 1ns/100ps
`include "sfb_consts.svh"
module sfb_top
	import sfb_pkg::*;
(
	input  wire logic       CLK_SYS_IN,
	input  wire logic       RESETN_IN,
	input  wire logic       ADDR_STROBE_N_IN,
	input  wire logic       WRITE_NREAD_IN,
	input  wire logic       LAST_TRANSFER_N_IN,
	input  wire logic [1:0] ADDR_BITS_IN,
	input  wire logic       FLASH_SPACE_HIT_IN,
	input  wire logic       OPT_CONFIG_IN,
	input  wire sfb_word_t  FLASH_DATA_IN,
	input  wire logic       CPU_DATA_READY_IN,
	output logic            FLASH_WE_N_OUT,
	output logic            FLASH_OE_N_OUT,
	output logic            FLASH_ADDR_VALID_N_OUT,
	output logic            FLASH_CS_N_OUT,
	output sfb_cnt_t        BURST_COUNT_OUT,
	output logic            READY_RECEIVE_N_OUT,
	output sfb_word_t       CPU_DATA_OUT,
	output logic            CPU_DATA_VALID_OUT
);
	logic       rst_meta_ff;
	logic       rst_n;
	sfb_state_t state_ff;
	sfb_state_t nxt_state;
	sfb_cnt_t   burst_count_ff;
	logic [2:0] wait_ff;
	logic [1:0] issue_ff;
	logic       we_n_ff;
	logic       oe_n_ff;
	logic       adv_n_ff;
	logic       nxt_adv_n;
	logic       rdy_n_ff;
	logic       cs_act_ff;
	logic       cs_tail_ff;
	logic       cs_n_ff;
	logic       nxt_cs_act;
	logic       nxt_cs_tail;
	logic       start;
	logic       wr_start;
	logic       rd_start;
	logic       last;
	logic       capture;
	logic       opt_issue;
	sfb_buf_if  rdq ();

	function automatic sfb_cnt_t count_up(input sfb_cnt_t c);
		count_up = sfb_cnt_t'(c + 2'h1);
	endfunction

	// processor bus shares this clock, so its pins are sampled directly
	assign start    = !ADDR_STROBE_N_IN && FLASH_SPACE_HIT_IN;
	assign wr_start = start && WRITE_NREAD_IN;
	assign rd_start = start && !WRITE_NREAD_IN;
	assign last     = !LAST_TRANSFER_N_IN;
	assign capture  = (state_ff == ST_R_WAIT) && (wait_ff == 3'h0) && rdq.push_ready;
	assign opt_issue = OPT_CONFIG_IN && (issue_ff != `SFB_OPT_ISSUES)
		&& ((state_ff == ST_R_ADDR) || (state_ff == ST_R_WAIT));

	// reset release through two flops
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// sequencing of write and read cycles
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (wr_start) begin
					nxt_state = ST_WE_A;
				end else if (rd_start) begin
					nxt_state = ST_R_ADDR;
				end
			end
			ST_WE_A: nxt_state = ST_WE_B;
			ST_WE_B: nxt_state = ST_W_GAP;
			ST_W_GAP: begin
				if (!OPT_CONFIG_IN) begin
					nxt_state = last ? ST_IDLE : ST_W_HOLD;
				end else begin
					nxt_state = last ? ST_IDLE : ST_WE_A;
				end
			end
			ST_W_HOLD: begin
				if (last) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_R_ADDR: nxt_state = cs_act_ff ? ST_R_WAIT : ST_IDLE;
			ST_R_WAIT: begin
				if (capture && last) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// burst counter: load at cycle start, step per word
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			burst_count_ff <= `SFB_CNT_RST;
		end else if (state_ff == ST_IDLE && start) begin
			burst_count_ff <= ADDR_BITS_IN;
		end else if (state_ff == ST_W_GAP && OPT_CONFIG_IN && !last) begin
			burst_count_ff <= count_up(burst_count_ff);
		end else if (opt_issue || (capture && !last && !OPT_CONFIG_IN)) begin
			burst_count_ff <= count_up(burst_count_ff);
		end
	end

	// read latency and optimized issue counters
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff  <= 3'h0;
			issue_ff <= 2'h0;
		end else if (state_ff == ST_R_ADDR) begin
			wait_ff  <= OPT_CONFIG_IN ? `SFB_RD_FIRST_OPT : `SFB_RD_FIRST_INIT;
			issue_ff <= opt_issue ? 2'h1 : 2'h0;
		end else if (state_ff == ST_R_WAIT) begin
			if (capture) begin
				wait_ff <= OPT_CONFIG_IN ? `SFB_RD_NEXT_OPT : `SFB_RD_NEXT_INIT;
			end else if (wait_ff != 3'h0) begin
				wait_ff <= wait_ff - 3'h1;
			end
			if (opt_issue) begin
				issue_ff <= issue_ff + 2'h1;
			end
		end else begin
			issue_ff <= 2'h0;
		end
	end

	// address-valid strobe for the next edge
	always_comb begin
		nxt_adv_n = 1'b1;
		if (state_ff == ST_IDLE && rd_start) begin
			nxt_adv_n = 1'b0;
		end else if (opt_issue) begin
			nxt_adv_n = 1'b0;
		end else if (capture && !last && !OPT_CONFIG_IN) begin
			nxt_adv_n = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			adv_n_ff <= 1'b1;
			rdy_n_ff <= 1'b1;
		end else begin
			adv_n_ff <= nxt_adv_n;
			rdy_n_ff <= !((state_ff == ST_WE_B) || capture);
		end
	end

	// write and output strobes change on the falling edge
	always_ff @(negedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			we_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
		end else begin
			we_n_ff <= !((state_ff == ST_WE_A) || (state_ff == ST_WE_B));
			oe_n_ff <= !(state_ff == ST_R_WAIT);
		end
	end

	// chip select held through the access plus one tail clock
	always_comb begin
		nxt_cs_act  = cs_act_ff;
		nxt_cs_tail = 1'b0;
		if (start) begin
			nxt_cs_act = 1'b1;
		end else if (cs_act_ff && last && ADDR_STROBE_N_IN) begin
			nxt_cs_act  = 1'b0;
			nxt_cs_tail = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			cs_act_ff  <= 1'b0;
			cs_tail_ff <= 1'b0;
			cs_n_ff    <= 1'b1;
		end else begin
			cs_act_ff  <= nxt_cs_act;
			cs_tail_ff <= nxt_cs_tail;
			cs_n_ff    <= !(nxt_cs_act || nxt_cs_tail);
		end
	end

	assign rdq.push_valid = capture;
	assign rdq.push_data  = FLASH_DATA_IN;
	assign rdq.pop_ready  = CPU_DATA_READY_IN;

	sfb_buf sfb_buf_i (
		.clk_in   (CLK_SYS_IN),
		.rst_n_in (rst_n),
		.bus      (rdq)
	);

	assign FLASH_WE_N_OUT         = we_n_ff;
	assign FLASH_OE_N_OUT         = oe_n_ff;
	assign FLASH_ADDR_VALID_N_OUT = adv_n_ff;
	assign FLASH_CS_N_OUT         = cs_n_ff;
	assign BURST_COUNT_OUT        = burst_count_ff;
	assign READY_RECEIVE_N_OUT    = rdy_n_ff;
	assign CPU_DATA_OUT           = rdq.pop_data;
	assign CPU_DATA_VALID_OUT     = rdq.pop_valid;

	property p_wr_start;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_IDLE && wr_start) |=> state_ff == ST_WE_A ##1 state_ff == ST_WE_B;
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write cycle did not start");

	property p_cnt_load;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_IDLE && start) |=> burst_count_ff == $past(ADDR_BITS_IN);
	endproperty
	a_cnt_load: assert property (p_cnt_load)
		else $error("counter missed address bits");

	property p_we_fall;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_IDLE && wr_start) |=> !we_n_ff;
	endproperty
	a_we_fall: assert property (p_we_fall)
		else $error("write strobe not low by second edge");

	property p_we_width;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		$fell(we_n_ff) |-> !we_n_ff ##1 !we_n_ff ##1 we_n_ff;
	endproperty
	a_we_width: assert property (p_we_width)
		else $error("write strobe width not two periods");

	property p_single;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_W_GAP && !OPT_CONFIG_IN && !last) |=> state_ff == ST_W_HOLD;
	endproperty
	a_single: assert property (p_single)
		else $error("burst write in power-up configuration");

	property p_hold_exit;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_W_HOLD && last) |=> state_ff == ST_IDLE;
	endproperty
	a_hold_exit: assert property (p_hold_exit)
		else $error("hold state ignored last transfer");

	property p_burst_step;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_W_GAP && OPT_CONFIG_IN && !last)
			|=> burst_count_ff == count_up($past(burst_count_ff)) ##1 !we_n_ff;
	endproperty
	a_burst_step: assert property (p_burst_step)
		else $error("burst write did not advance");

	property p_cs_tail;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(cs_act_ff && last && ADDR_STROBE_N_IN && !start) |=> !cs_n_ff ##1 (cs_n_ff || cs_act_ff);
	endproperty
	a_cs_tail: assert property (p_cs_tail)
		else $error("chip select tail not one clock");

	property p_cnt_stable;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_WE_B) |-> $stable(burst_count_ff);
	endproperty
	a_cnt_stable: assert property (p_cnt_stable)
		else $error("counter moved under write strobe");

	property p_ready;
		@(posedge CLK_SYS_IN) disable iff (!rst_n)
		(state_ff == ST_WE_B) |=> !READY_RECEIVE_N_OUT ##1 READY_RECEIVE_N_OUT;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready missing for write word");
endmodule

// ### shared/sfb_consts.svh
// constants of the synchronous flash burst sequencer
// assumes inclusion by the package and design files only
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH
`define SFB_CLK_PERIOD_NS   100
`define SFB_WE_PERIODS      2
`define SFB_RD_FIRST_INIT   3'h4
`define SFB_RD_FIRST_OPT    3'h2
`define SFB_RD_NEXT_INIT    3'h1
`define SFB_RD_NEXT_OPT     3'h0
`define SFB_OPT_ISSUES      2'h3
`define SFB_CNT_RST         2'h0
`define SFB_DATA_W          32
`define SFB_BUF_DEPTH       2
`endif

// ### shared/sfb_pkg.sv
// types of the synchronous flash burst sequencer
// assumes sfb_consts.svh is on the include path
`include "sfb_consts.svh"
package sfb_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WE_A,
		ST_WE_B,
		ST_W_GAP,
		ST_W_HOLD,
		ST_R_ADDR,
		ST_R_WAIT
	} sfb_state_t;
	typedef logic [`SFB_DATA_W-1:0] sfb_word_t;
	typedef logic [1:0]             sfb_cnt_t;
endpackage

// ### shared/sfb_buf_if.sv
// carrier between the sequencer and its two-entry read buffer
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface sfb_buf_if;
	import sfb_pkg::*;
	logic      push_valid;
	logic      push_ready;
	sfb_word_t push_data;
	logic      pop_valid;
	logic      pop_ready;
	sfb_word_t pop_data;
	modport store (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
	modport user (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data);
endinterface

// ### src/sfb_buf.sv
// two-entry buffer for words read from flash toward the processor
// assumes synchronous active-low reset copy from the top
`timescale 1ns/100ps
module sfb_buf
	import sfb_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	sfb_buf_if.store  bus
);
	sfb_word_t head_ff;
	sfb_word_t spare_ff;
	logic      head_vld_ff;
	logic      spare_vld_ff;
	logic      push_ok;
	logic      pop_ok;

	assign push_ok = bus.push_valid && !spare_vld_ff;
	assign pop_ok  = head_vld_ff && bus.pop_ready;
	assign bus.push_ready = !spare_vld_ff;
	assign bus.pop_valid  = head_vld_ff;
	assign bus.pop_data   = head_ff;

	// head register feeds the output; spare catches a word during a stall
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			head_vld_ff  <= 1'b0;
			spare_vld_ff <= 1'b0;
		end else begin
			if (pop_ok || !head_vld_ff) begin
				head_vld_ff  <= spare_vld_ff || push_ok;
				spare_vld_ff <= spare_vld_ff && push_ok;
			end else if (push_ok) begin
				spare_vld_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (pop_ok || !head_vld_ff) begin
			head_ff <= spare_vld_ff ? spare_ff : bus.push_data;
			if (spare_vld_ff && push_ok) begin
				spare_ff <= bus.push_data;
			end
		end else if (push_ok) begin
			spare_ff <= bus.push_data;
		end
	end

	property p_no_overrun;
		@(posedge clk_in) disable iff (!rst_n_in)
		(spare_vld_ff && !pop_ok) |=> spare_vld_ff && !bus.push_ready;
	endproperty
	a_no_overrun: assert property (p_no_overrun)
		else $error("buffer dropped its spare word");
endmodule

// ### bench/sfb_flash_model.sv
// behavioural burst flash facing the sequencer
// assumes the sequencer clock; released data bus shows inverted last word
`timescale 1ns/100ps
module sfb_flash_model
	import sfb_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     cs_n_in,
	input  wire logic     oe_n_in,
	input  wire logic     av_n_in,
	input  wire logic     rr_n_in,
	input  wire sfb_cnt_t cnt_in,
	output sfb_word_t     data_out
);
	sfb_cnt_t  aq [0:7];
	logic [2:0] wp;
	logic [2:0] rp;
	sfb_word_t  last_w;
	initial begin
		wp = 3'h0;
		rp = 3'h0;
		last_w = 32'h0;
	end
	// addresses latched on valid-address edges, dropped when a word is taken
	always @(posedge clk_in) begin
		if (cs_n_in) begin
			wp <= 3'h0;
			rp <= 3'h0;
		end else begin
			if (!rr_n_in && rp != wp) begin
				rp <= rp + 3'h1;
			end
			if (!av_n_in) begin
				aq[wp] <= cnt_in;
				wp <= wp + 3'h1;
			end
		end
		if (!oe_n_in) begin
			last_w <= data_out;
		end
	end
	assign data_out = oe_n_in ? ~last_w : {16'hf1a5, 14'h0, aq[rp + {2'h0, ~rr_n_in}]};
endmodule

// ### bench/sync_flash_burst_bus_interface_tb.sv
// self-checking bench of the burst flash sequencer
// assumes the flash model beside it; processor side driven on falling edges
`timescale 1ns/100ps
module sync_flash_burst_bus_interface_tb;
	import sfb_pkg::*;
	logic      clk = 1'b0;
	logic      rst_n = 1'b0;
	logic      as_n = 1'b1;
	logic      wr = 1'b0;
	logic      last_n = 1'b1;
	logic [1:0] addr = 2'h0;
	logic      hit = 1'b0;
	logic      opt = 1'b0;
	logic      take = 1'b0;
	sfb_word_t fd;
	logic      we_n, oe_n, av_n, cs_n, rr_n, dv;
	sfb_cnt_t  cnt;
	sfb_word_t dout;
	int        n_errors = 0;
	int        total_checks = 0;
	int        pulses;
	int        got;
	always #50 clk = ~clk;
	sfb_top sfb_top_i (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .ADDR_STROBE_N_IN(as_n),
		.WRITE_NREAD_IN(wr), .LAST_TRANSFER_N_IN(last_n), .ADDR_BITS_IN(addr),
		.FLASH_SPACE_HIT_IN(hit), .OPT_CONFIG_IN(opt), .FLASH_DATA_IN(fd),
		.CPU_DATA_READY_IN(take), .FLASH_WE_N_OUT(we_n), .FLASH_OE_N_OUT(oe_n),
		.FLASH_ADDR_VALID_N_OUT(av_n), .FLASH_CS_N_OUT(cs_n), .BURST_COUNT_OUT(cnt),
		.READY_RECEIVE_N_OUT(rr_n), .CPU_DATA_OUT(dout), .CPU_DATA_VALID_OUT(dv));
	sfb_flash_model sfb_flash_model_i (.clk_in(clk), .cs_n_in(cs_n), .oe_n_in(oe_n),
		.av_n_in(av_n), .rr_n_in(rr_n), .cnt_in(cnt), .data_out(fd));
	task automatic chk_bit(input string what, input logic exp, input logic seen);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic chk_word(input string what, input sfb_word_t exp, input sfb_word_t seen);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
		#1;
	endtask
	// strobe for one edge, returns half a cycle after it
	task automatic request(input logic w, input logic [1:0] a);
		as_n = 1'b0;
		wr = w;
		hit = 1'b1;
		addr = a;
		step(1);
		as_n = 1'b1;
		hit = 1'b0;
	endtask
	task automatic finish_cycle();
		last_n = 1'b0;
		step(1);
		last_n = 1'b1;
		chk_bit("cs_n", 1'b0, cs_n);
		step(1);
		chk_bit("cs_n", 1'b1, cs_n);
	endtask
	task automatic idle_outputs(input sfb_cnt_t c);
		chk_word("idle", 32'h1f, {27'h0, we_n, oe_n, av_n, cs_n, rr_n});
		chk_word("count", {30'h0, c}, {30'h0, cnt});
		chk_bit("dv", 1'b0, dv);
	endtask
	task automatic write_single();
		request(1'b1, 2'h2);
		chk_word("count", 32'h2, {30'h0, cnt});
		chk_bit("cs_n", 1'b0, cs_n);
		chk_bit("we_n", 1'b0, we_n);
		step(1);
		chk_bit("we_n", 1'b0, we_n);
		step(1);
		chk_bit("rr_n", 1'b0, rr_n);
		chk_bit("we_n", 1'b1, we_n);
		step(3);
		chk_bit("we_n", 1'b1, we_n);
		chk_bit("cs_n", 1'b0, cs_n);
		finish_cycle();
	endtask
	task automatic write_burst();
		opt = 1'b1;
		request(1'b1, 2'h3);
		chk_bit("we_n", 1'b0, we_n);
		step(2);
		chk_bit("we_n", 1'b1, we_n);
		chk_bit("rr_n", 1'b0, rr_n);
		step(1);
		chk_word("count", 32'h0, {30'h0, cnt});
		chk_bit("we_n", 1'b0, we_n);
		step(2);
		chk_bit("we_n", 1'b1, we_n);
		last_n = 1'b0;
		step(1);
		last_n = 1'b1;
		chk_bit("we_n", 1'b1, we_n);
		chk_word("count", 32'h0, {30'h0, cnt});
		step(2);
		chk_bit("cs_n", 1'b1, cs_n);
	endtask
	task automatic read_single();
		opt = 1'b0;
		request(1'b0, 2'h1);
		chk_bit("av_n", 1'b0, av_n);
		step(1);
		chk_bit("av_n", 1'b1, av_n);
		chk_bit("oe_n", 1'b0, oe_n);
		step(4);
		chk_bit("rr_n", 1'b1, rr_n);
		step(1);
		chk_bit("rr_n", 1'b0, rr_n);
		chk_bit("av_n", 1'b0, av_n);
		chk_word("count", 32'h2, {30'h0, cnt});
		step(1);
		chk_bit("rr_n", 1'b1, rr_n);
		chk_word("data", 32'hf1a50001, dout);
		last_n = 1'b0;
		step(1);
		last_n = 1'b1;
		chk_bit("rr_n", 1'b0, rr_n);
		step(1);
		chk_bit("oe_n", 1'b1, oe_n);
		chk_bit("dv", 1'b1, dv);
		take = 1'b1;
		step(1);
		chk_word("data", 32'hf1a50002, dout);
		step(1);
		take = 1'b0;
		chk_bit("dv", 1'b0, dv);
	endtask
	// four-word burst read with the consumer stalled for twelve clocks, past the point where the buffer refuses
	task automatic read_burst_stall();
		opt = 1'b1;
		pulses = 0;
		got = 0;
		request(1'b0, 2'h2);
		fork
			begin
				for (int t = 0; t < 60 && pulses < 4; t++) begin
					if (rr_n === 1'b0) pulses++;
					if (pulses == 3) last_n = 1'b0;
					step(1);
				end
				last_n = 1'b1;
			end
			begin
				step(12);
				chk_word("stalled", 32'h2, 32'(pulses));
				take = 1'b1;
				for (int t = 0; t < 40 && got < 4; t++) begin
					if (dv === 1'b1) begin
						chk_word("data", {16'hf1a5, 14'h0, sfb_cnt_t'(got + 2)}, dout);
						got++;
					end
					step(1);
				end
				take = 1'b0;
			end
		join
		chk_word("words", 32'h4, 32'(got));
		step(3);
		idle_outputs(2'h1);
	endtask
	task automatic conclude();
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		idle_outputs(2'h0);
		step(1);
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		step(1);
		idle_outputs(2'h0);
		write_single();
		write_burst();
		read_single();
		read_burst_stall();
		conclude();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule
